// *** cpu_jump_consts.vh ***
`ifndef CPU_JUMP_CONSTS_VH
`define CPU_JUMP_CONSTS_VH
// Opcodes handled by this executor
`define OP_ABS_JUMP 8'hC3
`define OP_REL_JUMP 8'h18
`define OP_REL_JUMP_NZ 8'h20
`define OP_REL_JUMP_Z 8'h28
`define OP_REL_JUMP_NC 8'h30
`define OP_REL_JUMP_C 8'h38
`define OP_LD_A_BCI 8'h0A
`define OP_LD_A_DEI 8'h1A
`define OP_LD_A_NN 8'h3A
`define OP_PFX_ED 8'hED
`define OP_PFX_FD 8'hFD
`define OP_LD_A_IV 8'h57
`define OP_INDEX_JUMP 8'hE9
// Machine cycle lengths in T states
`define T_FETCH 3'd4
`define T_MEM 3'd3
`define T_LONG 3'd5
// Flag bit positions
`define FLAG_S 7
`define FLAG_Z 6
`define FLAG_H 4
`define FLAG_PV 2
`define FLAG_N 1
`define FLAG_C 0
// Reset values
`define PC_RESET 16'h0000
`define FLAGS_RESET 8'hFF
`define ACC_RESET 8'hFF
// AHB-Lite register byte offsets
`define REG_PC 8'h00
`define REG_ACC 8'h04
`define REG_FLAGS 8'h08
`define REG_PAIRS 8'h0C
`define REG_INDEX 8'h10
`define REG_MISC 8'h14
`define REG_STATUS 8'h18
`define REG_CTRL 8'h1C
`endif

// *** tstate_timer.v ***
`timescale 1ns/1ps
`include "cpu_jump_consts.vh"
// Counts the T states of one machine cycle; last marks its final state
module tstate_timer (
  input wire hclk, // Clock
  input wire hresetn, // Async reset, active low
  input wire start, // Begin a machine cycle
  input wire [2:0] length, // T states in this cycle
  output reg busy, // Cycle in progress
  output wire last // Final T state of the cycle
);
  reg [2:0] count_reg;

  // Down counter loaded at start
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      count_reg <= 3'h0;
      busy <= 1'b0;
    end else if (start) begin
      count_reg <= length - 3'h1;
      busy <= 1'b1;
    end else if (busy) begin
      count_reg <= count_reg - 3'h1;
      if (count_reg == 3'h1) busy <= 1'b0;
    end
  end

  assign last = busy && (count_reg == 3'h1);
endmodule // tstate_timer

// *** rel_target.v ***
`timescale 1ns/1ps
// Sign-extends the displacement and adds it to the twice incremented counter
module rel_target (
  input wire [15:0] pc_after, // Counter after both bytes fetched
  input wire [7:0] disp, // Signed displacement byte
  output wire [15:0] target // Jump target, modulo 65536
);
  assign target = pc_after + {{8{disp[7]}}, disp};
endmodule // rel_target

// *** cpu_jump_exec.v ***
// Design decisions made here: the placing of the registers and the AHB-Lite register port.
`timescale 1ns/1ps
`include "cpu_jump_consts.vh"
// Overview of operation
// - Indirect jump through second index pointer loads counter, 8 states split 4,4.
// - Absolute jump loads 16-bit operand, low byte first, 10 states 4,3,3.
// - Relative jump adds signed displacement; span -126..+129 from opcode.
// - Opcode 18 always branches in 12 states 4,3,5.
// - Displacement added to counter after both bytes fetched.
// - Opcode 38 branches only when carry is 1.
// - Opcode 30 branches only when carry is 0.
// - Opcode 20 branches only when zero flag is 0.
// - Opcode 28 branches only when zero flag is 1.
// - Conditional jumps take 12 states taken, 7 states (4,3) not taken.
// - Jumps and memory loads leave all flags unchanged.
// - Opcode 0A loads accumulator from memory at counter_pair, 7 states.
// - Opcode 1A loads accumulator from memory at target_pair, 7 states.
// - Direct load takes address low byte first, 13 states 4,3,3,3.
// - Prefix ED then 57 copies interrupt vector into accumulator.
// - Interrupt vector load takes 9 states split 4,5.
// - Vector load sets S,Z, clears H,N, P/V from saved_interrupt_enable, keeps C.
module cpu_jump_exec (
  input wire hclk, // Clock, 40 MHz
  input wire hresetn, // Async reset, active low
  input wire [31:0] haddr, // AHB address
  input wire [1:0] htrans, // AHB transfer type
  input wire hwrite, // AHB write
  input wire [2:0] hsize, // AHB size
  input wire [31:0] hwdata, // AHB write data
  input wire hsel, // AHB select
  input wire hready, // AHB bus ready
  output reg [31:0] hrdata, // AHB read data
  output reg hreadyout, // AHB slave ready
  output reg hresp, // AHB response, always OKAY
  output reg [15:0] mem_addr, // Memory address
  output reg mem_rd, // Memory read strobe
  input wire [7:0] mem_data // Memory read data
);
  localparam S_IDLE = 8'h01;
  localparam S_FETCH = 8'h02;
  localparam S_OP1 = 8'h04;
  localparam S_OP2 = 8'h08;
  localparam S_RDMEM = 8'h10;
  localparam S_FETCH2 = 8'h20;
  localparam S_INTERNAL = 8'h40;
  localparam S_DONE = 8'h80;

  reg [7:0] state_reg;
  reg [15:0] pc_reg;
  reg [7:0] acc_reg;
  reg [7:0] flags_reg;
  reg [15:0] counter_pair_reg;
  reg [15:0] target_pair_reg;
  reg [15:0] second_index_pointer_reg;
  reg [7:0] ivec_reg;
  reg saved_interrupt_enable_reg;
  reg [7:0] op_reg;
  reg prefix_reg;
  reg [7:0] lo_reg;
  reg [7:0] tstates_reg;
  reg [2:0] mcycles_reg;
  reg run_reg;
  reg halt_reg;
  reg start;
  reg [2:0] length;
  wire busy;
  wire last;
  wire [15:0] rel_pc;
  reg cond_ok;
  reg wr_pend_reg;
  reg [7:0] wr_addr_reg;

  tstate_timer u_timer (
    .hclk(hclk),
    .hresetn(hresetn),
    .start(start),
    .length(length),
    .busy(busy),
    .last(last)
  );

  rel_target u_rel (
    .pc_after(pc_reg),
    .disp(lo_reg),
    .target(rel_pc)
  );

  // Condition test for the relative jumps
  always @* begin
    case (op_reg)
      `OP_REL_JUMP: cond_ok = 1'b1;
      `OP_REL_JUMP_C: cond_ok = flags_reg[`FLAG_C];
      `OP_REL_JUMP_NC: cond_ok = ~flags_reg[`FLAG_C];
      `OP_REL_JUMP_NZ: cond_ok = ~flags_reg[`FLAG_Z];
      `OP_REL_JUMP_Z: cond_ok = flags_reg[`FLAG_Z];
      default: cond_ok = 1'b0;
    endcase
  end

  // Instruction sequencer: one machine cycle per state, timed by u_timer
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= S_IDLE;
      pc_reg <= `PC_RESET;
      acc_reg <= `ACC_RESET;
      flags_reg <= `FLAGS_RESET;
      op_reg <= 8'h00;
      prefix_reg <= 1'b0;
      lo_reg <= 8'h00;
      tstates_reg <= 8'h00;
      mcycles_reg <= 3'h0;
      halt_reg <= 1'b0;
      mem_addr <= 16'h0000;
      mem_rd <= 1'b0;
      start <= 1'b0;
      length <= `T_FETCH;
    end else begin
      start <= 1'b0;
      // Count the load clock of each machine cycle as well as its busy clocks
      if (busy || start) tstates_reg <= tstates_reg + 8'h01;
      // Halt clear comes first so that a halt raised in the same cycle wins
      if (wr_pend_reg && !run_reg && wr_addr_reg == `REG_CTRL && hwdata[1]) halt_reg <= 1'b0;
      case (state_reg)
        S_IDLE: begin
          mem_rd <= 1'b0;
          if (run_reg && !halt_reg && !busy && !start) begin
            mem_addr <= pc_reg;
            mem_rd <= 1'b1;
            start <= 1'b1;
            length <= `T_FETCH;
            tstates_reg <= 8'h00;
            mcycles_reg <= 3'h1;
            prefix_reg <= 1'b0;
            state_reg <= S_FETCH;
          end
        end
        S_FETCH: if (last) begin
          op_reg <= mem_data;
          pc_reg <= pc_reg + 16'h0001;
          mem_rd <= 1'b0;
          mcycles_reg <= mcycles_reg + 3'h1;
          start <= 1'b1;
          case (mem_data)
            `OP_PFX_ED, `OP_PFX_FD: begin
              prefix_reg <= 1'b1;
              length <= (mem_data == `OP_PFX_ED) ? `T_LONG : `T_FETCH;
              mem_addr <= pc_reg + 16'h0001;
              mem_rd <= 1'b1;
              state_reg <= S_FETCH2;
            end
            `OP_LD_A_BCI: begin
              mem_addr <= counter_pair_reg;
              mem_rd <= 1'b1;
              length <= `T_MEM;
              state_reg <= S_RDMEM;
            end
            `OP_LD_A_DEI: begin
              mem_addr <= target_pair_reg;
              mem_rd <= 1'b1;
              length <= `T_MEM;
              state_reg <= S_RDMEM;
            end
            `OP_ABS_JUMP, `OP_LD_A_NN, `OP_REL_JUMP, `OP_REL_JUMP_C, `OP_REL_JUMP_NC, `OP_REL_JUMP_NZ,
            `OP_REL_JUMP_Z: begin
              mem_addr <= pc_reg + 16'h0001;
              mem_rd <= 1'b1;
              length <= `T_MEM;
              state_reg <= S_OP1;
            end
            default: begin
              start <= 1'b0;
              mcycles_reg <= mcycles_reg;
              halt_reg <= 1'b1; // Unsupported opcode stops execution
              state_reg <= S_DONE;
            end
          endcase
        end
        S_FETCH2: if (last) begin
          // Second opcode byte fetched in a 5-state machine cycle after ED, a 4-state one after FD
          mem_rd <= 1'b0;
          pc_reg <= pc_reg + 16'h0001;
          state_reg <= S_DONE;
          if (op_reg == `OP_PFX_FD && mem_data == `OP_INDEX_JUMP) begin
            pc_reg <= second_index_pointer_reg;
          end else if (op_reg == `OP_PFX_ED && mem_data == `OP_LD_A_IV) begin
            acc_reg <= ivec_reg;
            flags_reg[`FLAG_S] <= ivec_reg[7];
            flags_reg[`FLAG_Z] <= (ivec_reg == 8'h00);
            flags_reg[`FLAG_H] <= 1'b0;
            flags_reg[`FLAG_N] <= 1'b0;
            flags_reg[`FLAG_PV] <= saved_interrupt_enable_reg;
          end else begin
            halt_reg <= 1'b1;
          end
        end
        S_OP1: if (last) begin
          lo_reg <= mem_data; // Low byte or displacement
          pc_reg <= pc_reg + 16'h0001;
          mem_rd <= 1'b0;
          state_reg <= S_DONE;
          if (op_reg == `OP_ABS_JUMP || op_reg == `OP_LD_A_NN) begin
            mem_addr <= pc_reg + 16'h0001;
            mem_rd <= 1'b1;
            start <= 1'b1;
            length <= `T_MEM;
            mcycles_reg <= mcycles_reg + 3'h1;
            state_reg <= S_OP2;
          end else if (cond_ok) begin
            start <= 1'b1;
            length <= `T_LONG;
            mcycles_reg <= mcycles_reg + 3'h1;
            state_reg <= S_INTERNAL;
          end
        end
        S_OP2: if (last) begin
          mem_rd <= 1'b0;
          if (op_reg == `OP_ABS_JUMP) begin
            pc_reg <= {mem_data, lo_reg};
            state_reg <= S_DONE;
          end else begin
            pc_reg <= pc_reg + 16'h0001;
            mem_addr <= {mem_data, lo_reg};
            mem_rd <= 1'b1;
            start <= 1'b1;
            length <= `T_MEM;
            mcycles_reg <= mcycles_reg + 3'h1;
            state_reg <= S_RDMEM;
          end
        end
        S_RDMEM: if (last) begin
          acc_reg <= mem_data; // Flags untouched
          mem_rd <= 1'b0;
          state_reg <= S_DONE;
        end
        S_INTERNAL: if (last) begin
          pc_reg <= rel_pc;
          state_reg <= S_DONE;
        end
        S_DONE: begin
          mem_rd <= 1'b0;
          state_reg <= S_IDLE;
        end
        default: state_reg <= S_IDLE;
      endcase
      // Software writes to core registers when the core is stopped
      if (wr_pend_reg && !run_reg) begin
        case (wr_addr_reg)
          `REG_PC: pc_reg <= hwdata[15:0];
          `REG_ACC: acc_reg <= hwdata[7:0];
          `REG_FLAGS: flags_reg <= hwdata[7:0];
          default: ;
        endcase
      end
    end
  end

  // AHB-Lite slave: zero wait states, always OKAY
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_pend_reg <= 1'b0;
      wr_addr_reg <= 8'h00;
      run_reg <= 1'b0;
      counter_pair_reg <= 16'h0000;
      target_pair_reg <= 16'h0000;
      second_index_pointer_reg <= 16'h0000;
      ivec_reg <= 8'h00;
      saved_interrupt_enable_reg <= 1'b0;
    end else begin
      wr_pend_reg <= 1'b0;
      if (wr_pend_reg) begin
        case (wr_addr_reg)
          `REG_PAIRS: begin
            counter_pair_reg <= hwdata[15:0];
            target_pair_reg <= hwdata[31:16];
          end
          `REG_INDEX: second_index_pointer_reg <= hwdata[15:0];
          `REG_MISC: begin
            ivec_reg <= hwdata[7:0];
            saved_interrupt_enable_reg <= hwdata[8];
          end
          `REG_CTRL: run_reg <= hwdata[0];
          default: ;
        endcase
      end
      if (hsel && hready && htrans[1]) begin
        if (hwrite) begin
          wr_pend_reg <= 1'b1;
          wr_addr_reg <= haddr[7:0];
        end else begin
          case (haddr[7:0])
            `REG_PC: hrdata <= {16'h0000, pc_reg};
            `REG_ACC: hrdata <= {24'h000000, acc_reg};
            `REG_FLAGS: hrdata <= {24'h000000, flags_reg};
            `REG_PAIRS: hrdata <= {target_pair_reg, counter_pair_reg};
            `REG_INDEX: hrdata <= {16'h0000, second_index_pointer_reg};
            `REG_MISC: hrdata <= {23'h000000, saved_interrupt_enable_reg, ivec_reg};
            `REG_STATUS: hrdata <= {13'h0000, mcycles_reg, tstates_reg, 6'h00,
                                    halt_reg, (state_reg != S_IDLE)};
            `REG_CTRL: hrdata <= {31'h00000000, run_reg};
            default: hrdata <= 32'h00000000;
          endcase
        end
      end
    end
  end
endmodule // cpu_jump_exec

// *** mem_model.sv ***
`timescale 1ns/1ps
// Byte-wide program and data memory on the executor's read port
module mem_model (
  input wire hclk, // Clock
  input wire [15:0] mem_addr, // Address
  input wire mem_rd, // Read strobe
  output logic [7:0] mem_data // Read data
);
  logic [7:0] mem [0:65535];
  // Unwritten bytes read as zero
  initial begin
    for (int i = 0; i < 65536; i++) mem[i] = 8'h00;
    mem_data = 8'h5A;
  end
  // Place one byte
  task put(input logic [15:0] a, input logic [7:0] d);
    mem[a] = d;
  endtask
  // Answer one edge after the address; while not read the line toggles
  always @(posedge hclk) begin
    if (mem_rd) mem_data <= mem[mem_addr];
    else mem_data <= ~mem_data;
  end
endmodule // mem_model

// *** cpu_jump_exec_properties.sv ***
`timescale 1ns/1ps
// Watches the executor's ports
module cpu_jump_exec_checker (
  input wire hclk, // Clock
  input wire hresetn, // Reset, active low
  input wire [31:0] haddr, // Address
  input wire [1:0] htrans, // Transfer type
  input wire hwrite, // Write
  input wire [2:0] hsize, // Size
  input wire [31:0] hwdata, // Write data
  input wire hsel, // Select
  input wire hready, // Bus ready
  input wire [31:0] hrdata, // Read data
  input wire hreadyout, // Slave ready
  input wire hresp, // Response
  input wire [15:0] mem_addr, // Memory address
  input wire mem_rd, // Memory read
  input wire [7:0] mem_data // Memory data
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic [4:0] run_len;
  wire rd_req = hsel && hready && htrans[1] && !hwrite;
  // Length of the current unbroken read stretch
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) run_len <= 5'h00;
    else run_len <= mem_rd ? run_len + 5'h01 : 5'h00;
  end
  property p_ready; hreadyout; endproperty
  a_ready: assert property (p_ready) else $error("slave not ready");
  property p_okay; !hresp; endproperty
  a_okay: assert property (p_okay) else $error("response not okay");
  property p_stand; !rd_req |=> $stable(hrdata); endproperty
  a_stand: assert property (p_stand) else $error("read data moved");
  property p_unmapped; rd_req && haddr[31:8] == 24'h0 && haddr[7:5] != 3'h0 |=> hrdata == 32'h0; endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_hold; mem_rd && $changed(mem_addr) |=> (mem_rd && $stable(mem_addr)) [*2]; endproperty
  a_hold: assert property (p_hold) else $error("read cycle address moved");
  property p_min; $rose(mem_rd) |=> mem_rd [*2]; endproperty
  a_min: assert property (p_min) else $error("read cycle too short");
  property p_fell; $fell(mem_rd) |-> $past(mem_rd, 3); endproperty
  a_fell: assert property (p_fell) else $error("read ended early");
  property p_max; run_len <= 5'd13; endproperty
  a_max: assert property (p_max) else $error("read stretch too long");
endmodule // cpu_jump_exec_checker
bind cpu_jump_exec cpu_jump_exec_checker chk_i (.hclk(hclk), .hresetn(hresetn), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hsel(hsel), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_data(mem_data));

// *** cpu_jump_and_accumulator_load_bench.sv ***
`timescale 1ns/1ps
module cpu_jump_and_accumulator_load_bench;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  logic [1:0] htrans = 2'b00;
  wire [31:0] hrdata;
  wire hreadyout, hresp, mem_rd;
  wire [15:0] mem_addr;
  wire [7:0] mem_data;
  int err_count = 0;
  int checked = 0;
  int cyc = 0;
  // Clock of 25 ns
  initial forever #12.5 hclk = ~hclk;
  cpu_jump_exec DUT (.hclk(hclk), .hresetn(hresetn), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'b010), .hwdata(hwdata), .hsel(1'b1), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_data(mem_data));
  mem_model mem (.hclk(hclk), .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_data(mem_data));
  task close_out;
    $display("checks %0d errors %0d", checked, err_count);
    if (err_count == 0 && checked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Cycle ceiling against hangs
  always @(posedge hclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      close_out;
    end
  end
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One single word transfer; read data lands in rd
  task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge hclk);
    haddr <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Run one instruction from pc0 with flags f and check counter, timing, flags
  task step(input logic [15:0] pc0, input logic [7:0] f, input logic [15:0] epc, input logic [7:0] et,
            input logic [2:0] em, input logic [7:0] ef);
    int n;
    ahb(1'b1, 8'h00, {16'h0, pc0});
    ahb(1'b1, 8'h08, {24'h0, f});
    ahb(1'b1, 8'h1C, 32'h1);
    ahb(1'b1, 8'h1C, 32'h0);
    n = 0;
    do begin
      ahb(1'b0, 8'h18, 32'h0);
      n++;
    end while (rd[0] !== 1'b0 && n < 50);
    chk(rd[18:8], {em, et});
    ahb(1'b0, 8'h00, 32'h0);
    chk(rd[15:0], epc);
    ahb(1'b0, 8'h08, 32'h0);
    chk(rd[7:0], ef);
  endtask
  task t_reset;
    ahb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h0);
    ahb(1'b0, 8'h04, 32'h0);
    chk(rd, 32'hFF);
    ahb(1'b0, 8'h24, 32'h0);
    chk(rd, 32'h0);
    $display("reset test done");
  endtask
  task t_jr;
    mem.put(16'h0480, 8'h18);
    mem.put(16'h0481, 8'h03);
    step(16'h0480, 8'hFF, 16'h0485, 8'd12, 3'd3, 8'hFF);
    mem.put(16'h1000, 8'h18);
    mem.put(16'h1001, 8'h80);
    step(16'h1000, 8'h00, 16'h0F82, 8'd12, 3'd3, 8'h00);
    mem.put(16'h1001, 8'h7F);
    step(16'h1000, 8'h00, 16'h1081, 8'd12, 3'd3, 8'h00);
    mem.put(16'hFFFE, 8'h18);
    mem.put(16'hFFFF, 8'h05);
    step(16'hFFFE, 8'h00, 16'h0005, 8'd12, 3'd3, 8'h00);
    $display("relative jump test done");
  endtask
  task t_cond;
    logic [7:0] ops [4];
    logic tk;
    ops = '{8'h38, 8'h30, 8'h20, 8'h28};
    mem.put(16'h0481, 8'hFA);
    for (int i = 0; i < 8; i++) begin
      mem.put(16'h0480, ops[i/2]);
      tk = (i % 2 == 1) == (ops[i/2][3] == 1'b1);
      if (tk) step(16'h0480, (i % 2) ? 8'hFF : 8'h00, 16'h047C, 8'd12, 3'd3, (i % 2) ? 8'hFF : 8'h00);
      else step(16'h0480, (i % 2) ? 8'hFF : 8'h00, 16'h0482, 8'd7, 3'd2, (i % 2) ? 8'hFF : 8'h00);
    end
    $display("conditional jump test done");
  endtask
  task t_jp;
    mem.put(16'h0200, 8'hC3);
    mem.put(16'h0201, 8'h34);
    mem.put(16'h0202, 8'h12);
    step(16'h0200, 8'hFF, 16'h1234, 8'd10, 3'd3, 8'hFF);
    ahb(1'b1, 8'h10, 32'h4800);
    mem.put(16'h0100, 8'hFD);
    mem.put(16'h0101, 8'hE9);
    step(16'h0100, 8'h00, 16'h4800, 8'd8, 3'd2, 8'h00);
    $display("absolute jump test done");
  endtask
  task t_load;
    ahb(1'b1, 8'h0C, 32'h30A2_4747);
    mem.put(16'h4747, 8'h12);
    mem.put(16'h30A2, 8'h22);
    mem.put(16'h8832, 8'h04);
    mem.put(16'h0300, 8'h0A);
    mem.put(16'h0301, 8'h1A);
    mem.put(16'h0302, 8'h3A);
    mem.put(16'h0303, 8'h32);
    mem.put(16'h0304, 8'h88);
    step(16'h0300, 8'h00, 16'h0301, 8'd7, 3'd2, 8'h00);
    ahb(1'b0, 8'h04, 32'h0);
    chk(rd[7:0], 8'h12);
    step(16'h0301, 8'hFF, 16'h0302, 8'd7, 3'd2, 8'hFF);
    ahb(1'b0, 8'h04, 32'h0);
    chk(rd[7:0], 8'h22);
    step(16'h0302, 8'h00, 16'h0305, 8'd13, 3'd4, 8'h00);
    ahb(1'b0, 8'h04, 32'h0);
    chk(rd[7:0], 8'h04);
    $display("load test done");
  endtask
  task t_vec;
    mem.put(16'h0400, 8'hED);
    mem.put(16'h0401, 8'h57);
    ahb(1'b1, 8'h14, 32'h80);
    step(16'h0400, 8'h01, 16'h0402, 8'd9, 3'd2, 8'h81);
    ahb(1'b0, 8'h04, 32'h0);
    chk(rd[7:0], 8'h80);
    ahb(1'b1, 8'h14, 32'h100);
    step(16'h0400, 8'h00, 16'h0402, 8'd9, 3'd2, 8'h44);
    $display("vector load test done");
  endtask
  // Reset, then the scenarios
  initial begin
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset;
    t_jr;
    t_cond;
    t_jp;
    t_load;
    t_vec;
    close_out;
  end
endmodule // cpu_jump_and_accumulator_load_bench
